//--- rtl/sfsc_status_unit.sv
// Purpose: status register command unit of a serial flash
// Assumes: host drives cs_n and sck; sck idles between frames
// Notes:   frame data is held stable in the link domain while cs_n is
//          high and is read by the system domain after cs_n resyncs
`timescale 1ns/10ps

// Behaviour
// - arm cleared by any other command
// - arm command leaves write latch alone
// - three opcodes select status byte
// - status shifted out msb first, falling edge
// - status reads accepted while busy
// - status byte repeats until cs_n high
// - writes change writable bits only
// - lock bits fall only on soft reset; protect_mode_bit_b held on volatile writes only
// - nonvolatile write needs write latch set
// - armed write updates volatile copy only
// - reset reloads status from nonvolatile copy
// - timed nv cycle sets busy, clears latch
// - volatile refresh delay without busy
// - quad mode blocks quad enable writes
// - sixteen data bits write bytes one, two
// - eight data bits write own byte only
// - enter opcode switches to four lines
// - exit opcode returns to single line
// - suspend and resume in both modes
// - suspend flags at bits ten, fifteen
// - suspend settles within latency bound
// - write enable sets write latch
module sfsc_status_unit #(
  parameter int NV_WRITE_CYCLES    = sfsc_pkg::NV_WRITE_CYCLES,
  parameter int VOL_REFRESH_CYCLES = sfsc_pkg::VOL_REFRESH_CYCLES,
  parameter int SUSPEND_CYCLES     = sfsc_pkg::SUSPEND_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic        sw_reset,
  input  wire logic        pe_busy,
  input  wire logic        pe_is_program,
  input  wire logic        pe_done,
  input  wire logic        pe_error,
  output logic      [23:0] status_word,
  output logic             quad_command_mode,
  output logic             pe_suspend
);

  // ****************************************************************
  // link domain
  // ****************************************************************
  logic        in_frame;
  logic [23:0] rx_bits;
  logic [5:0]  rx_count;
  logic [7:0]  op_reg;
  logic        quad_link;
  logic [23:0] stat_l;
  logic [5:0]  base_count;
  logic [23:0] next_rx_bits;
  logic [5:0]  next_rx_count;
  logic [7:0]  rd_byte;
  logic        rd_op;
  logic [2:0]  rd_idx;

  // status word as seen by the link, resynced on sck
  sfsc_sync3 #(.W(24), .RST(24'h000000)) u_stat_sync (
    .clk   (sck),
    .rst_n (nrst),
    .d     (status_word),
    .q     (stat_l)
  );

  // frame marker, dropped as soon as cs_n rises
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // next shift value, one or four bits per rising edge
  always_comb begin
    base_count    = in_frame ? rx_count : 6'h00;
    next_rx_bits  = rx_bits;
    next_rx_count = base_count;
    if (base_count < sfsc_pkg::RX_FULL) begin
      if (quad_link) begin
        next_rx_bits  = {rx_bits[19:0], io_in};
        next_rx_count = base_count + 6'h04;
      end else begin
        next_rx_bits  = {rx_bits[22:0], io_in[0]};
        next_rx_count = base_count + 6'h01;
      end
    end
  end

  // capture of opcode and data bytes
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      rx_bits  <= 24'h000000;
      rx_count <= 6'h00;
      op_reg   <= 8'h00;
    end else begin
      rx_bits  <= next_rx_bits;
      rx_count <= next_rx_count;
      if (next_rx_count == sfsc_pkg::OP_BITS) begin
        op_reg <= next_rx_bits[7:0];
      end
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      quad_link <= 1'b0;
    end else if (next_rx_count == sfsc_pkg::OP_BITS) begin
      if (!quad_link && next_rx_bits[7:0] == sfsc_pkg::OP_QEN &&
          stat_l[sfsc_pkg::BIT_QE]) begin
        quad_link <= 1'b1;
      end else if (quad_link && next_rx_bits[7:0] == sfsc_pkg::OP_QEX) begin
        quad_link <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_op   = 1'b1;
    case (op_reg)
      sfsc_pkg::OP_RD1: rd_byte = stat_l[7:0];
      sfsc_pkg::OP_RD2: rd_byte = stat_l[15:8];
      sfsc_pkg::OP_RD3: rd_byte = stat_l[23:16];
      default: begin
        rd_byte = 8'h00;
        rd_op   = 1'b0;
      end
    endcase
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      io_out <= 4'h0;
      io_oe  <= 4'h0;
      rd_idx <= 3'h0;
    end else if (in_frame && rx_count >= sfsc_pkg::OP_BITS && rd_op) begin
      rd_idx <= rd_idx + 3'h1;
      if (quad_link) begin
        io_out <= rd_idx[0] ? rd_byte[3:0] : rd_byte[7:4];
        io_oe  <= 4'hf;
      end else begin
        io_out <= {2'b00, rd_byte[~rd_idx], 1'b0}; // data out on io1
        io_oe  <= 4'h2;
      end
    end
  end

  // ****************************************************************
  // system domain: frame end and decode
  // ****************************************************************
  localparam int CNT_W = sfsc_pkg::CNT_W;

  logic              cs_s;
  logic              cs_prev;
  logic              frame_end;
  logic              cmd_ok;
  logic              accept;
  logic [23:0]       wr_bytes;
  logic [23:0]       wr_data;
  logic [23:0]       m_eff;
  logic [23:0]       sr;
  logic [23:0]       nv;
  logic [23:0]       nv_pend;
  logic [23:0]       vol_val;
  logic [CNT_W-1:0]  nv_cnt;
  logic [CNT_W-1:0]  vol_cnt;
  logic [CNT_W-1:0]  sus_cnt;
  logic              nv_busy;
  logic              vol_pend;
  logic              sus_run;
  logic              nv_commit;
  logic              vol_commit;
  logic              sus_done;
  logic              write_enable_latch;
  logic              arm;
  logic              program_suspended_flag;
  logic              erase_suspended_flag;
  logic              pe_active;
  logic              do_wr;
  logic              do_nv;
  logic              do_vol;
  logic              do_sus;
  logic              do_res;

  // cs_n resync, rising edge marks the frame end
  sfsc_sync3 #(.W(1), .RST(1'b1)) u_cs_sync (
    .clk   (sys_clk),
    .rst_n (nrst),
    .d     (cs_n),
    .q     (cs_s)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_s;
    end
  end

  // merge of a write into a status image
  function automatic logic [23:0] f_merge(input logic [23:0] base,
                                          input logic [23:0] data,
                                          input logic [23:0] m,
                                          input logic        vol);
    logic [23:0] r;
    r = (base & ~m) | (data & m);
    r = r | (base & sfsc_pkg::OTP_MASK);
    if (vol) begin
      r = r | (base & sfsc_pkg::PROTECT_MODE_BIT_B_MASK);
    end
    return r & sfsc_pkg::WR_MASK;
  endfunction : f_merge

  assign frame_end = cs_s & ~cs_prev;
  assign cmd_ok    = frame_end && (rx_count >= sfsc_pkg::OP_BITS);
  assign accept    = cmd_ok && !nv_busy;
  assign nv_busy   = |nv_cnt;
  assign vol_pend  = |vol_cnt;
  assign sus_run   = |sus_cnt;
  assign nv_commit = nv_cnt == CNT_W'(1);
  assign vol_commit = vol_cnt == CNT_W'(1);
  assign sus_done  = sus_cnt == CNT_W'(1);
  assign pe_active = pe_busy | program_suspended_flag | erase_suspended_flag | sus_run;
  assign pe_suspend = program_suspended_flag | erase_suspended_flag | sus_run;

  // one byte into its own register, two bytes into registers one, two
  always_comb begin
    wr_bytes = 24'h000000;
    wr_data  = 24'h000000;
    case (op_reg)
      sfsc_pkg::OP_WR1: begin
        if (rx_count == sfsc_pkg::ONE_BYTE) begin
          wr_bytes = 24'h0000ff;
          wr_data  = {16'h0000, rx_bits[7:0]};
        end else if (rx_count == sfsc_pkg::RX_FULL) begin
          wr_bytes = 24'h00ffff;
          wr_data  = {8'h00, rx_bits[7:0], rx_bits[15:8]};
        end
      end
      sfsc_pkg::OP_WR2: begin
        if (rx_count == sfsc_pkg::ONE_BYTE) begin
          wr_bytes = 24'h00ff00;
          wr_data  = {8'h00, rx_bits[7:0], 8'h00};
        end
      end
      sfsc_pkg::OP_WR3: begin
        if (rx_count == sfsc_pkg::ONE_BYTE) begin
          wr_bytes = 24'hff0000;
          wr_data  = {rx_bits[7:0], 16'h0000};
        end
      end
      default: begin
        wr_bytes = 24'h000000;
        wr_data  = 24'h000000;
      end
    endcase
  end

  // quad enable masked in quad mode
  assign m_eff = sfsc_pkg::WR_MASK & wr_bytes &
                 ~(quad_command_mode ? sfsc_pkg::QE_MASK : 24'h000000);

  // no latch and no arm ignores it
  assign do_wr  = accept && (|wr_bytes) && !pe_active && !vol_pend &&
                  (arm || write_enable_latch);
  assign do_vol = do_wr && arm;
  assign do_nv  = do_wr && !arm;
  // no mode check on suspend and resume
  assign do_sus = accept && op_reg == sfsc_pkg::OP_SUSP && pe_busy &&
                  !program_suspended_flag && !erase_suspended_flag && !sus_run;
  assign do_res = accept && op_reg == sfsc_pkg::OP_RES;

  // ****************************************************************
  // system domain: state
  // ****************************************************************

  // arm lost on any other command
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arm <= 1'b0;
    end else if (sw_reset) begin
      arm <= 1'b0;
    end else if (cmd_ok) begin
      arm <= accept && op_reg == sfsc_pkg::OP_VARM;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0;
    end else if (sw_reset) begin
      write_enable_latch <= 1'b0;
    end else if (accept && op_reg == sfsc_pkg::OP_WREN) begin
      write_enable_latch <= 1'b1;
    end else if ((accept && op_reg == sfsc_pkg::OP_WRDI) || nv_commit ||
                 pe_done || sus_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nv_cnt  <= '0;
      nv_pend <= sfsc_pkg::NV_RESET;
    end else if (do_nv) begin
      nv_cnt  <= CNT_W'(NV_WRITE_CYCLES);
      nv_pend <= f_merge(nv, wr_data, m_eff, 1'b0);
    end else if (nv_busy) begin
      nv_cnt <= nv_cnt - CNT_W'(1);
    end
  end

  // nonvolatile image, kept across soft reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nv <= sfsc_pkg::NV_RESET;
    end else if (nv_commit) begin
      nv <= nv_pend;
    end
  end

  // armed write goes to volatile copy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vol_cnt <= '0;
      vol_val <= sfsc_pkg::NV_RESET;
    end else if (sw_reset) begin
      vol_cnt <= '0;
    end else if (do_vol) begin
      vol_cnt <= CNT_W'(VOL_REFRESH_CYCLES);
      vol_val <= f_merge(sr, wr_data, m_eff, 1'b1);
    end else if (vol_pend) begin
      vol_cnt <= vol_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sr <= sfsc_pkg::NV_RESET;
    end else if (sw_reset) begin
      sr <= nv;
    end else begin
      if (nv_commit) begin
        sr <= nv_pend | (sr & sfsc_pkg::OTP_MASK);
      end else if (vol_commit) begin
        sr <= vol_val;
      end
      if (pe_error) begin
        sr[sfsc_pkg::BIT_PERR] <= 1'b1; // error event beats a write
      end
    end
  end

  // quad mode mirrored at frame end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      quad_command_mode <= 1'b0;
    end else if (cmd_ok) begin
      if (!quad_command_mode && op_reg == sfsc_pkg::OP_QEN &&
          sr[sfsc_pkg::BIT_QE]) begin
        quad_command_mode <= 1'b1;
      end else if (quad_command_mode && op_reg == sfsc_pkg::OP_QEX) begin
        quad_command_mode <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sus_cnt <= '0;
    end else if (do_res) begin
      sus_cnt <= '0;
    end else if (do_sus) begin
      sus_cnt <= CNT_W'(SUSPEND_CYCLES);
    end else if (sus_run) begin
      sus_cnt <= sus_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end else begin
      if (do_res) begin
        program_suspended_flag <= 1'b0;
        erase_suspended_flag <= 1'b0;
      end
      if (sus_done) begin
        program_suspended_flag <= pe_is_program;
        erase_suspended_flag <= !pe_is_program;
      end
    end
  end

  // busy and latch into status word
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_word <= 24'h000000;
    end else begin
      status_word <= {sr[23:16], erase_suspended_flag, sr[14:11], program_suspended_flag, sr[9:2], write_enable_latch,
                      nv_busy | sus_run | (pe_busy & ~program_suspended_flag & ~erase_suspended_flag)};
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_arm_keeps_wel: assert property (
    accept && op_reg == sfsc_pkg::OP_VARM && !sw_reset && !pe_done &&
    !sus_done |=> $stable(write_enable_latch))
    else $error("arm opcode changed write latch");
  a_arm_cleared: assert property (
    cmd_ok && op_reg != sfsc_pkg::OP_VARM |=> !arm)
    else $error("arm survived another command");
  a_nv_busy_run: assert property (
    do_nv |=> nv_busy [*8])
    else $error("nv write cycle ended too early");
  a_nv_end_wel: assert property (
    $fell(nv_busy) |-> !write_enable_latch ##1 !status_word[sfsc_pkg::BIT_BUSY])
    else $error("latch or busy left set after nv write");
  a_vol_no_busy: assert property (
    do_vol |=> vol_pend && !status_word[sfsc_pkg::BIT_BUSY])
    else $error("busy set during volatile refresh");
  a_vol_bound: assert property (
    $rose(vol_pend) |-> ##[1:1000] !vol_pend)
    else $error("volatile refresh never ended");
  a_otp_hold: assert property (
    !$past(sw_reset) |->
      (($past(sr) & ~sr & sfsc_pkg::OTP_MASK) == 24'h000000))
    else $error("lock bit cleared");
  a_quad_qe: assert property (
    quad_command_mode && $past(quad_command_mode) &&
    $past(sr[sfsc_pkg::BIT_QE]) && !$past(sw_reset) |->
      sr[sfsc_pkg::BIT_QE])
    else $error("quad enable dropped in quad mode");
  a_sus_bound: assert property (
    do_sus |-> ##[1:1000] (program_suspended_flag || erase_suspended_flag || !sus_run))
    else $error("suspend latency exceeded");
  a_sus_flag: assert property (
    sus_done && !do_res |=> (program_suspended_flag != erase_suspended_flag) ##1
      (status_word[sfsc_pkg::BIT_PROGRAM_SUSPENDED_FLAG] == program_suspended_flag &&
       status_word[sfsc_pkg::BIT_ERASE_SUSPENDED_FLAG] == erase_suspended_flag))
    else $error("suspend flag not shown");
  a_ignore_bare: assert property (
    accept && (|wr_bytes) && !write_enable_latch && !arm && !vol_pend |=>
      !nv_busy && !vol_pend)
    else $error("unenabled status write started");
  a_one_byte: assert property (
    op_reg == sfsc_pkg::OP_WR1 && rx_count == sfsc_pkg::ONE_BYTE |->
      wr_bytes[23:8] == 16'h0000)
    else $error("single byte write reached register two");

  c_nv_write:  cover property (nv_commit ##1 (!nv_busy && !write_enable_latch));
  c_vol_write: cover property (do_vol ##[1:100] vol_commit);
  c_quad_in:   cover property ($rose(quad_command_mode));
  c_suspend:   cover property (do_sus ##[1:1000] sus_done);

endmodule : sfsc_status_unit

//--- rtl/sfsc_pkg.sv
// Purpose: constants shared by the status command unit and its helpers
// Assumes: 25 MHz system clock, status word is three bytes wide
// Notes:   status bits 0 and 1 and the suspend flags are not stored in
//          the writable image; they are merged into the status word
package sfsc_pkg;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VARM = 8'h50;
  localparam logic [7:0] OP_RD1  = 8'h05;
  localparam logic [7:0] OP_RD2  = 8'h35;
  localparam logic [7:0] OP_RD3  = 8'h15;
  localparam logic [7:0] OP_WR1  = 8'h01;
  localparam logic [7:0] OP_WR2  = 8'h31;
  localparam logic [7:0] OP_WR3  = 8'h11;
  localparam logic [7:0] OP_QEN  = 8'h38;
  localparam logic [7:0] OP_QEX  = 8'hff;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RES  = 8'h7a;

  // ****************************************************************
  // status word layout (bit positions in the 24-bit word)
  // ****************************************************************
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL  = 1;
  localparam int BIT_PROTECT_MODE_BIT_B = 8;
  localparam int BIT_QE   = 9;
  localparam int BIT_PROGRAM_SUSPENDED_FLAG = 10;
  localparam int BIT_ERASE_SUSPENDED_FLAG = 15;
  localparam int BIT_PERR = 18;
  localparam logic [23:0] WR_MASK   = 24'he4_7b_fc; // writable bits
  localparam logic [23:0] OTP_MASK  = 24'h00_38_00; // info row locks
  localparam logic [23:0] PROTECT_MODE_BIT_B_MASK = 24'h00_01_00;
  localparam logic [23:0] QE_MASK   = 24'h00_02_00;
  localparam logic [23:0] NV_RESET  = 24'h00_00_00;

  // ****************************************************************
  // frame geometry
  // ****************************************************************
  localparam logic [5:0] OP_BITS  = 6'h08;
  localparam logic [5:0] ONE_BYTE = 6'h10;
  localparam logic [5:0] RX_FULL  = 6'h18;
  localparam int         CNT_W    = 20;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_NS         = 40;
  localparam int NV_WRITE_TIME_NS   = 5000000;
  localparam int VOL_REFRESH_NS     = 1000;
  localparam int SUSPEND_LAT_NS     = 20000;
  localparam int NV_WRITE_CYCLES    =
    (NV_WRITE_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int VOL_REFRESH_CYCLES =
    (VOL_REFRESH_NS / SYS_CLK_NS) < 1 ? 1 : VOL_REFRESH_NS / SYS_CLK_NS;
  localparam int SUSPEND_CYCLES     =
    (SUSPEND_LAT_NS / SYS_CLK_NS) < 1 ? 1 : SUSPEND_LAT_NS / SYS_CLK_NS;

endpackage : sfsc_pkg

//--- rtl/sfsc_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes:   q follows only once stages two and three agree
`timescale 1ns/10ps

module sfsc_sync3 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= RST[i];
        end else if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  endgenerate

endmodule : sfsc_sync3

//--- test/sfsc_host.sv
// Purpose: host side of the serial link, frames commands, reads data
// Assumes: mode 0 clocking, sck idles low outside frames
// Notes:   released data lines get the inverse of their last value
`timescale 1ns/10ps

module sfsc_host (
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out
);
  // ********
  // frame engine
  // ********
  logic quad = 1'b0; // four lines per edge once quad mode is on

  // idle link before the first frame
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h0;
  end

  // opcode and data sent whole under one select
  task automatic frame(input logic [23:0] tx, input int nb, input int nr,
                       output logic [15:0] rd);
    rd   = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i += (quad ? 4 : 1)) begin
      #16 io_in = (i >= nb) ? ~io_in :
                  quad ? tx[23-i -: 4] : {3'h0, tx[23-i]};
      #16 sck = 1'b1;
      if (i >= nb)
        rd = quad ? {rd[11:0], io_out} : {rd[14:0], io_out[1]};
      #32 sck = 1'b0;
    end
    #16 cs_n = 1'b1;
    io_in = ~io_in; // released lines must not hold the last value
    #600;           // deselect time before the next frame
  endtask : frame
endmodule : sfsc_host

//--- test/sfsc_status_unit_tb.sv
// Purpose: self-checking bench for the status command unit
// Assumes: shortened write and suspend timings, host model on the link
// Notes:   expected words are built from the writable bit masks
`timescale 1ns/10ps

module sfsc_status_unit_tb;
  // ********
  // harness
  // ********
  logic        sys_clk       = 1'b0;
  logic        nrst          = 1'b0;
  logic        sw_reset      = 1'b0;
  logic        pe_busy       = 1'b0;
  logic        pe_is_program = 1'b0;
  logic        pe_done       = 1'b0;
  logic        pe_error      = 1'b0;
  logic        sck, cs_n, qcm, susp;
  logic [3:0]  io_in, io_out, io_oe;
  logic [23:0] sw;
  logic [15:0] rd;
  int          n_fail        = 0;
  int          checks_done   = 0;

  always #20 sys_clk = ~sys_clk;

  sfsc_status_unit #(.NV_WRITE_CYCLES(200), .VOL_REFRESH_CYCLES(25),
    .SUSPEND_CYCLES(50)) uut (.sys_clk(sys_clk), .nrst(nrst), .sck(sck),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .sw_reset(sw_reset), .pe_busy(pe_busy), .pe_is_program(pe_is_program),
    .pe_done(pe_done), .pe_error(pe_error), .status_word(sw),
    .quad_command_mode(qcm), .pe_suspend(susp));

  sfsc_host host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [23:0] tx, input int nb, input int nr);
    cyc(1);
    host.frame(tx, nb, nr, rd);
    cyc(1); // realign the bench to the system clock
  endtask : cmd

  task automatic op(input logic [7:0] o);
    cmd({o, 16'h0000}, 8, 0);
  endtask : op

  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    cmd({o, d, 8'h00}, 16, 0);
  endtask : wr

  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // watchdog well beyond the expected run length
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end

  // command sequences with expected status words
  initial begin
    cyc(2);
    nrst = 1'b1;
    cyc(4);
    chk(sw, 24'h000000);
    cmd({sfsc_pkg::OP_RD1, 16'h0000}, 8, 16);
    chk({8'h00, rd}, 24'h000000);
    wr(sfsc_pkg::OP_WR1, 8'hfc);
    chk(sw, 24'h000000);
    op(sfsc_pkg::OP_WREN);
    chk(sw, 24'h000002);
    wr(sfsc_pkg::OP_WR1, 8'hfc);
    chk(sw, 24'h000003);
    cmd({sfsc_pkg::OP_RD1, 16'h0000}, 8, 16);
    chk({8'h00, rd}, 24'h000303);
    cyc(250);
    chk(sw, 24'h0000fc);
    fork
      cmd({sfsc_pkg::OP_RD1, 16'h0000}, 8, 16);
      begin
        #1400;
        chk({20'h00000, io_oe}, 24'h000002);
      end
    join
    chk({8'h00, rd}, 24'h00fcfc);
    chk({20'h00000, io_oe}, 24'h000000);
    op(sfsc_pkg::OP_WREN);
    cmd({sfsc_pkg::OP_WR1, 16'hffff}, 24, 0);
    cyc(250);
    chk(sw, 24'h007bfc);
    op(sfsc_pkg::OP_WREN);
    wr(sfsc_pkg::OP_WR1, 8'h00);
    cyc(250);
    chk(sw, 24'h007b00);
    // an intervening read drops the arm
    op(sfsc_pkg::OP_VARM);
    cmd({sfsc_pkg::OP_RD1, 16'h0000}, 8, 8);
    wr(sfsc_pkg::OP_WR2, 8'h00);
    cyc(40);
    chk(sw, 24'h007b00);
    op(sfsc_pkg::OP_VARM);
    wr(sfsc_pkg::OP_WR2, 8'h02);
    chk({22'h0, sw[1:0]}, 24'h000000);
    cyc(30);
    chk(sw, 24'h003b00);
    op(sfsc_pkg::OP_WREN);
    op(sfsc_pkg::OP_VARM);
    chk(sw, 24'h003b02);
    op(sfsc_pkg::OP_WRDI);
    op(sfsc_pkg::OP_QEN);
    chk({23'h0, qcm}, 24'h000001);
    host.quad = 1'b1;
    op(sfsc_pkg::OP_VARM);
    wr(sfsc_pkg::OP_WR2, 8'h00);
    cyc(30);
    chk(sw, 24'h003b00);
    cmd({sfsc_pkg::OP_RD2, 16'h0000}, 8, 16);
    chk({8'h00, rd}, 24'h003b3b);
    pe_busy = 1'b1;
    op(sfsc_pkg::OP_SUSP);
    chk({23'h0, susp}, 24'h000001);
    cyc(60);
    chk(sw, 24'h00bb00);
    op(sfsc_pkg::OP_RES);
    chk(sw, 24'h003b01);
    // settle time before the next suspend
    cyc(2500);
    op(sfsc_pkg::OP_QEX);
    host.quad = 1'b0;
    chk({23'h0, qcm}, 24'h000000);
    pe_is_program = 1'b1;
    op(sfsc_pkg::OP_SUSP);
    cyc(60);
    chk(sw, 24'h003f00);
    op(sfsc_pkg::OP_RES);
    pe_busy = 1'b0;
    op(sfsc_pkg::OP_WREN);
    wr(sfsc_pkg::OP_WR3, 8'hff);
    cyc(250);
    chk({sw[23:16], 16'h0}, 24'he40000);
    sw_reset = 1'b1;
    cyc(1);
    sw_reset = 1'b0;
    cyc(5);
    chk(sw, 24'he47b00);
    op(sfsc_pkg::OP_VARM);
    wr(sfsc_pkg::OP_WR3, 8'h00);
    cyc(30);
    pe_error = 1'b1;
    cyc(1);
    pe_error = 1'b0;
    cyc(2);
    chk({sw[23:16], 16'h0}, 24'h040000);
    sw_reset = 1'b1;
    cyc(1);
    sw_reset = 1'b0;
    cyc(5);
    chk({sw[23:16], 16'h0}, 24'he40000);
    cmd({sfsc_pkg::OP_RD3, 16'h0000}, 8, 16);
    chk({8'h00, rd}, 24'h00e4e4);
    op(sfsc_pkg::OP_WREN);
    pe_done = 1'b1;
    cyc(1);
    pe_done = 1'b0;
    cyc(2);
    chk({23'h0, sw[1]}, 24'h000000);
    complete_run();
  end
endmodule : sfsc_status_unit_tb
